// ===== common/ibf_pkg.sv
package ibf_pkg;
	// register byte addresses
	localparam logic [3:0] FILTER_CTRL_ADDR = 4'h0;
	localparam logic [3:0] RANGE_LIMIT_ADDR = 4'h4;
	localparam logic [3:0] MATCH_CTRL_ADDR  = 4'h8;
	localparam logic [3:0] IRQ_STATUS_ADDR  = 4'hc;
	// filter/event control fields
	localparam int STOP_SEEN_BIT   = 6;
	localparam int COND_IRQ_EN_BIT = 5;
	localparam int START_SEEN_BIT  = 4;
	localparam int GLITCH_LSB      = 0;
	localparam int GLITCH_W        = 4;
	// match control fields
	localparam int RANGE_EN_BIT    = 0;
	localparam int MASTER_MODE_BIT = 1;
	localparam int ADDR_W          = 7;
	localparam logic [7:0] FILTER_CTRL_RESET = 8'h00;
	localparam logic [7:0] RANGE_LIMIT_RESET = 8'h00;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic scl;
		logic sda;
	} ibf_bus_t;
endpackage

// ===== logic/ibf_event_filter.sv
// Function
// - stop-seen bit reads 1 after a stop is observed as addressed slave outside master mode, 0 otherwise.
// - bit 5 enable lets start or stop detection request the module interrupt.
// - module irq flag re-asserts if cleared while start/stop flags remain set.
// - start-seen flag bit 4 set on start; write 1 clears, write 0 ignored.
// - filter blocks pulses no longer than the programmed width in clock cycles.
// - glitch width 0 bypasses filter; 1 to 15 suppress up to that many cycles.
// - upper match address holds a 7-bit slave address for comparison.
// - with range matching on, a nonzero write activates the upper address.
// - in range mode, upper address is the highest accepted slave address.
// - bit 0 of the range address register is reserved and reads 0.
// - stop-seen flag set on stop; only writing 1 clears it.
// - stop-seen only set as addressed slave, never as master.
`timescale 1ns/1ns
`default_nettype none
module ibf_event_filter (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// axi4-lite write address
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [3:0]        s_axi_awaddr,
	// axi4-lite write data
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// axi4-lite write response
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// axi4-lite read
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [3:0]        s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// serial bus pins
	input  wire ibf_pkg::ibf_bus_t bus_in,
	// slave-side context from the transfer engine
	input  wire logic              slave_addressed,
	input  wire logic [6:0]        rx_slave_addr,
	// filtered bus and events
	output ibf_pkg::ibf_bus_t      bus_filt,
	output logic                   range_hit,
	output logic                   start_pulse,
	output logic                   stop_pulse,
	// interrupt
	output logic                   irq
);
	// synchronisers
	ibf_pkg::ibf_bus_t sync1_reg, sync2_reg;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end else begin
			sync1_reg <= bus_in;
			sync2_reg <= sync1_reg;
		end
	end

	// registers
	logic [7:0] filt_ctrl_reg;
	logic [7:0] range_reg;
	logic       range_act_reg;
	logic [1:0] match_ctrl_reg;
	logic       irq_flag_reg;
	logic       irq_mask_reg;
	wire  [3:0] glitch_w = filt_ctrl_reg[ibf_pkg::GLITCH_LSB +: ibf_pkg::GLITCH_W];

	// one filter per line: a change passes only once stable for more than width cycles
	// each line owns its flops so no vector has two processes driving it
	wire  [1:0] filt_q_reg;
	wire  [1:0] raw = {sync2_reg.scl, sync2_reg.sda};
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_filt
			logic       q_reg;
			logic [3:0] cnt_reg;
			wire differs = raw[g] != q_reg;
			wire settled = (glitch_w == 4'h0) || (cnt_reg == glitch_w);
			assign filt_q_reg[g] = q_reg;
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					q_reg   <= 1'b1;
					cnt_reg <= 4'h0;
				end else if (!differs) begin
					cnt_reg <= 4'h0;
				end else if (settled) begin
					q_reg   <= raw[g];
					cnt_reg <= 4'h0;
				end else begin
					cnt_reg <= cnt_reg + 4'h1;
				end
			end
		end
	endgenerate
	// filtered levels: [1]=scl, [0]=sda

	// start/stop detection on filtered lines
	logic prev_sda_reg;
	wire  start_det = filt_q_reg[1] && prev_sda_reg && !filt_q_reg[0];
	wire  stop_det  = filt_q_reg[1] && !prev_sda_reg && filt_q_reg[0];
	wire  stop_valid = stop_det && slave_addressed && !match_ctrl_reg[ibf_pkg::MASTER_MODE_BIT];

	// axi write channel
	logic       aw_held_reg, w_held_reg;
	logic [3:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire wr_go   = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire wr_lane = w_strb_reg[0];
	wire wr_flt  = wr_go && wr_lane && (aw_addr_reg == ibf_pkg::FILTER_CTRL_ADDR);
	wire wr_ra   = wr_go && wr_lane && (aw_addr_reg == ibf_pkg::RANGE_LIMIT_ADDR);
	wire wr_mc   = wr_go && wr_lane && (aw_addr_reg == ibf_pkg::MATCH_CTRL_ADDR);
	wire wr_irq  = wr_go && wr_lane && (aw_addr_reg == ibf_pkg::IRQ_STATUS_ADDR);
	wire wr_hit  = (aw_addr_reg == ibf_pkg::FILTER_CTRL_ADDR) || (aw_addr_reg == ibf_pkg::RANGE_LIMIT_ADDR) ||
	               (aw_addr_reg == ibf_pkg::MATCH_CTRL_ADDR) || (aw_addr_reg == ibf_pkg::IRQ_STATUS_ADDR);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= 4'h0;
			w_data_reg    <= 32'h0;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ibf_pkg::AXI_OKAY;
		end else begin
			s_axi_awready <= !aw_held_reg && !aw_take;
			s_axi_wready  <= !w_held_reg && !w_take;
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[3:2], 2'h0};
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? ibf_pkg::AXI_OKAY : ibf_pkg::AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// event flags: hardware set wins over a same-cycle clear
	wire start_clr = wr_flt && w_data_reg[ibf_pkg::START_SEEN_BIT];
	wire stop_clr  = wr_flt && w_data_reg[ibf_pkg::STOP_SEEN_BIT];
	wire start_nx  = start_det || (filt_ctrl_reg[ibf_pkg::START_SEEN_BIT] && !start_clr);
	wire stop_nx   = stop_valid || (filt_ctrl_reg[ibf_pkg::STOP_SEEN_BIT] && !stop_clr);
	wire cond_req  = filt_ctrl_reg[ibf_pkg::COND_IRQ_EN_BIT] &&
	                 (filt_ctrl_reg[ibf_pkg::START_SEEN_BIT] || filt_ctrl_reg[ibf_pkg::STOP_SEEN_BIT]);
	// module flag keeps setting while a condition flag is still pending
	wire irq_flag_nx = cond_req || (irq_flag_reg && !(wr_irq && w_data_reg[0]));
	wire [6:0] ra_wval = w_data_reg[7:1];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			filt_ctrl_reg  <= ibf_pkg::FILTER_CTRL_RESET;
			range_reg      <= ibf_pkg::RANGE_LIMIT_RESET;
			range_act_reg  <= 1'b0;
			match_ctrl_reg <= 2'h0;
			irq_flag_reg   <= 1'b0;
			irq_mask_reg   <= 1'b0;
			prev_sda_reg   <= 1'b1;
			start_pulse    <= 1'b0;
			stop_pulse     <= 1'b0;
			range_hit      <= 1'b0;
			irq            <= 1'b0;
			bus_filt       <= '1;
		end else begin
			prev_sda_reg <= filt_q_reg[0];
			if (wr_flt) begin
				filt_ctrl_reg[ibf_pkg::COND_IRQ_EN_BIT] <= w_data_reg[ibf_pkg::COND_IRQ_EN_BIT];
				filt_ctrl_reg[3:0] <= w_data_reg[3:0];
			end
			filt_ctrl_reg[ibf_pkg::START_SEEN_BIT] <= start_nx;
			filt_ctrl_reg[ibf_pkg::STOP_SEEN_BIT]  <= stop_nx;
			if (wr_ra) begin
				range_reg <= {ra_wval, 1'b0};
				range_act_reg <= match_ctrl_reg[ibf_pkg::RANGE_EN_BIT] && (ra_wval != 7'h00);
			end
			if (wr_mc) begin
				match_ctrl_reg <= w_data_reg[1:0];
			end
			if (wr_irq) begin
				irq_mask_reg <= w_data_reg[8];
			end
			irq_flag_reg <= irq_flag_nx;
			start_pulse  <= start_det;
			stop_pulse   <= stop_valid;
			// upper bound of accepted range
			range_hit    <= match_ctrl_reg[ibf_pkg::RANGE_EN_BIT] && range_act_reg &&
			                (rx_slave_addr <= range_reg[7:1]);
			irq          <= irq_flag_reg && irq_mask_reg;
			bus_filt.scl <= filt_q_reg[1];
			bus_filt.sda <= filt_q_reg[0];
		end
	end

	// axi read channel, one cycle after address
	wire [3:0] ar_a = {s_axi_araddr[3:2], 2'h0};
	wire [31:0] rd_mux =
		(ar_a == ibf_pkg::FILTER_CTRL_ADDR) ? {24'h0, 1'b0, filt_ctrl_reg[6:0]} :
		(ar_a == ibf_pkg::RANGE_LIMIT_ADDR) ? {24'h0, range_reg[7:1], 1'b0} :
		(ar_a == ibf_pkg::MATCH_CTRL_ADDR)  ? {29'h0, range_act_reg, match_ctrl_reg} :
		(ar_a == ibf_pkg::IRQ_STATUS_ADDR)  ? {23'h0, irq_mask_reg, 7'h0, irq_flag_reg} : 32'h0;
	wire rd_hit = (ar_a == ibf_pkg::FILTER_CTRL_ADDR) || (ar_a == ibf_pkg::RANGE_LIMIT_ADDR) ||
	              (ar_a == ibf_pkg::MATCH_CTRL_ADDR) || (ar_a == ibf_pkg::IRQ_STATUS_ADDR);
	wire ar_take = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= ibf_pkg::AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_hit ? ibf_pkg::AXI_OKAY : ibf_pkg::AXI_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/ibf_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ibf_monitor (
	// clock and reset
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	// register bus
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [31:0]       s_axi_rdata,
	// serial bus side
	input wire ibf_pkg::ibf_bus_t bus_filt,
	input wire logic              slave_addressed,
	input wire logic              start_pulse,
	input wire logic              stop_pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
	a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	a_start_shape: assert property (start_pulse |-> bus_filt.scl && !bus_filt.sda && $past(bus_filt.sda))
		else $error("start without falling data");
	a_start_single: assert property (start_pulse |=> !start_pulse) else $error("start pulse too long");
	a_stop_shape: assert property (stop_pulse |-> bus_filt.scl && bus_filt.sda && !$past(bus_filt.sda))
		else $error("stop without rising data");
	a_stop_gated: assert property (!slave_addressed [*3] |-> !stop_pulse) else $error("stop seen as master");
endmodule
bind ibf_event_filter ibf_monitor mon (.*);
`default_nettype wire

// ===== tb/ibf_bus_partner.sv
`timescale 1ns/1ns
`default_nettype none
module ibf_bus_partner (
	input wire logic              sys_clk,
	output var ibf_pkg::ibf_bus_t bus
);
	// pull-ups hold both lines high when nobody drives
	initial bus = 2'h3;
	task automatic hold(input logic scl, input logic sda, input int n);
		@(posedge sys_clk);
		bus <= '{scl, sda};
		repeat (n - 1) @(posedge sys_clk);
	endtask
	task automatic start_cond();
		hold(1'h1, 1'h0, 20);
		hold(1'h0, 1'h0, 20);
	endtask
	task automatic stop_cond();
		hold(1'h1, 1'h0, 20);
		hold(1'h1, 1'h1, 20);
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam logic [3:0] CTL = ibf_pkg::FILTER_CTRL_ADDR, LIM = ibf_pkg::RANGE_LIMIT_ADDR;
	localparam logic [3:0] MCH = ibf_pkg::MATCH_CTRL_ADDR, STA = ibf_pkg::IRQ_STATUS_ADDR;
	logic sys_clk = 1'h0, sys_rst = 1'h1, slave_addressed = 1'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [6:0] rx_slave_addr = 7'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, range_hit, start_pulse, stop_pulse, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	ibf_pkg::ibf_bus_t bus_in, bus_filt;
	int num_errors = 0, check_count = 0;
	ibf_event_filter dut (.*);
	ibf_bus_partner bm (.sys_clk(sys_clk), .bus(bus_in));
	always #4 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask
	// one task for both directions; channels released one by one as taken
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!(s_axi_bvalid && s_axi_bready) && !(s_axi_rvalid && s_axi_rready));
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		acc(1'h0, a, 32'h0);
		chk(s_axi_rdata, exp);
	endtask
	task automatic complete_run();
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'h0;
		rd(CTL, 32'(ibf_pkg::FILTER_CTRL_RESET));
		acc(1'h1, CTL, 32'h20);
		acc(1'h1, STA, 32'h100);
		bm.start_cond();
		acc(1'h1, CTL, 32'h20);
		rd(CTL, 32'h30);
		acc(1'h1, STA, 32'h101);
		rd(STA, 32'h101);
		chk(32'(irq), 32'h1);
		acc(1'h1, CTL, 32'h30);
		acc(1'h1, STA, 32'h101);
		rd(STA, 32'h100);
		bm.stop_cond();
		rd(CTL, 32'h60);
		chk(32'(irq), 32'h1);
		acc(1'h1, CTL, 32'h40);
		acc(1'h1, STA, 32'h101);
		repeat (3) @(posedge sys_clk);
		chk(32'(irq), 32'h0);
		slave_addressed <= 1'h0;
		bm.start_cond();
		bm.stop_cond();
		rd(CTL, 32'h10);
		slave_addressed <= 1'h1;
		acc(1'h1, CTL, 32'h13);
		bm.hold(1'h1, 1'h0, 3);
		bm.hold(1'h1, 1'h1, 30);
		rd(CTL, 32'h03);
		bm.hold(1'h1, 1'h0, 4);
		bm.hold(1'h1, 1'h1, 30);
		rd(CTL, 32'h53);
		acc(1'h1, MCH, 32'h1);
		acc(1'h1, LIM, 32'h41);
		rd(LIM, 32'h40);
		rd(MCH, 32'h5);
		rx_slave_addr <= 7'h20;
		repeat (4) @(posedge sys_clk);
		chk(32'(range_hit), 32'h1);
		rx_slave_addr <= 7'h21;
		repeat (4) @(posedge sys_clk);
		chk(32'(range_hit), 32'h0);
		rd(4'h2, 32'h53);
		chk(32'(s_axi_rresp), 32'(ibf_pkg::AXI_OKAY));
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
